// >>> hw/rre_exec.sv
`include "rre_defines.svh"
`default_nettype none

//--------------------------------------------------------------
// return and rotate executor
//--------------------------------------------------------------
module rre_exec (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic op_valid,
  input wire rre_pkg::rre_op_e op_code,
  input wire rre_pkg::rre_byte_t op_literal,
  input wire rre_pkg::rre_faddr_t op_file_addr,
  input wire logic op_dest,
  output logic op_ready,
  output logic stack_pop,
  input wire rre_pkg::rre_pc_t top_of_stack,
  output rre_pkg::rre_faddr_t file_rd_addr,
  input wire rre_pkg::rre_byte_t file_rd_data,
  output var logic file_wr_en,
  output rre_pkg::rre_faddr_t file_wr_addr,
  output rre_pkg::rre_byte_t file_wr_data,
  input wire logic int_enable_clear,
  output rre_pkg::rre_byte_t interrupt_control_reg,
  output rre_pkg::rre_byte_t w_reg,
  output var logic carry,
  output rre_pkg::rre_pc_t pc
);
  import rre_pkg::*;

  //------------------------------------------------------------
  // state
  //------------------------------------------------------------
  rre_state_e state; // sequencing state
  rre_state_e next_state;
  rre_byte_t w; // working register
  rre_byte_t next_w;
  logic carry_q; // carry flag
  logic next_carry;
  logic int_enable; // global interrupt enable
  logic next_int_enable;
  rre_pc_t pc_q; // program counter
  rre_pc_t next_pc;
  logic wr_en; // registered file write
  logic next_wr_en;
  rre_faddr_t wr_addr;
  rre_faddr_t next_wr_addr;
  rre_byte_t wr_data;
  rre_byte_t next_wr_data;

  logic accept; // instruction taken this cycle
  logic is_ret; // one of the return forms
  rre_byte_t rot_result; // rotate unit result
  logic rot_cout; // rotate unit carry

  //------------------------------------------------------------
  // rotate unit
  //------------------------------------------------------------
  rre_rot_if rot ();

  assign rot.value_in = file_rd_data;
  assign rot.carry_in = carry_q;
  assign rot_result = rot.result;
  assign rot_cout = rot.carry_out;

  rre_rotate u_rotate (
    .rot(rot.unit)
  );

  //------------------------------------------------------------
  // handshakes
  //------------------------------------------------------------
  assign op_ready = (state == st_ready);
  assign accept = op_valid && op_ready;
  assign is_ret = (op_code == return_from_interrupt_op) ||
                  (op_code == return_with_literal_op) ||
                  (op_code == return_from_sub_op);
  // pop once, in the first cycle of a return
  assign stack_pop = accept && is_ret;
  assign file_rd_addr = op_file_addr;

  //------------------------------------------------------------
  // next-state logic
  //------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_w = w;
    next_carry = carry_q;
    next_int_enable = int_enable;
    next_pc = pc_q;
    next_wr_en = 1'b0;
    next_wr_addr = wr_addr;
    next_wr_data = wr_data;
    // interrupt entry clears; a set below in the same cycle wins
    if (int_enable_clear) begin
      next_int_enable = 1'b0;
    end
    unique case (state)
      st_ready: begin
        if (accept) begin
          unique case (op_code)
            return_from_interrupt_op: begin
              next_pc = top_of_stack;
              next_int_enable = 1'b1;
              next_state = st_flush;
            end
            return_with_literal_op: begin
              next_w = op_literal;
              next_pc = top_of_stack;
              next_state = st_flush;
            end
            return_from_sub_op: begin
              next_pc = top_of_stack;
              next_state = st_flush;
            end
            rotate_left_carry_op: begin
              next_carry = rot_cout;
              if (op_dest == `RRE_DEST_F) begin
                // write back to the source register
                next_wr_en = 1'b1;
                next_wr_addr = op_file_addr;
                next_wr_data = rot_result;
              end else begin
                // source left alone, result to working register
                next_w = rot_result;
              end
            end
            default: begin
              // idle slot, nothing to do
            end
          endcase
        end
      end
      st_flush: begin
        // second cycle of a return: fetch refill
        next_state = st_ready;
      end
    endcase
  end

  //------------------------------------------------------------
  // registers
  //------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      state <= st_ready;
      w <= `RRE_RST_BYTE;
      carry_q <= `RRE_RST_BIT;
      int_enable <= `RRE_RST_BIT;
      pc_q <= `RRE_RST_PC;
      wr_en <= `RRE_RST_BIT;
      wr_addr <= `RRE_RST_FADDR;
      wr_data <= `RRE_RST_BYTE;
    end else begin
      state <= next_state;
      w <= next_w;
      carry_q <= next_carry;
      int_enable <= next_int_enable;
      pc_q <= next_pc;
      wr_en <= next_wr_en;
      wr_addr <= next_wr_addr;
      wr_data <= next_wr_data;
    end
  end

  //------------------------------------------------------------
  // outputs
  //------------------------------------------------------------
  assign w_reg = w;
  assign carry = carry_q;
  assign pc = pc_q;
  assign file_wr_en = wr_en;
  assign file_wr_addr = wr_addr;
  assign file_wr_data = wr_data;
  // only the enable bit lives here; other bits read zero
  always_comb begin
    interrupt_control_reg = `RRE_RST_BYTE;
    interrupt_control_reg[`RRE_INT_EN_BIT] = int_enable;
  end

  //------------------------------------------------------------
  // checks
  //------------------------------------------------------------
  a_ret_pc_load: assert property (
    @(posedge mclk) disable iff (!rstn)
    accept && is_ret |=> pc == $past(top_of_stack))
    else $error("return did not load pc from stack");

  a_ret_two_cycle: assert property (
    @(posedge mclk) disable iff (!rstn)
    accept && is_ret |=> !op_ready ##1 op_ready)
    else $error("return did not take two cycles");

  a_rti_enable_set: assert property (
    @(posedge mclk) disable iff (!rstn)
    accept && op_code == return_from_interrupt_op |=>
      interrupt_control_reg[`RRE_INT_EN_BIT] && carry == $past(carry))
    else $error("interrupt return left enable clear or moved carry");

  a_lit_ret_w_load: assert property (
    @(posedge mclk) disable iff (!rstn)
    accept && op_code == return_with_literal_op |=>
      w_reg == $past(op_literal) && carry == $past(carry))
    else $error("literal return did not load working register");

  a_ret_flags_keep: assert property (
    @(posedge mclk) disable iff (!rstn)
    accept && op_code == return_from_sub_op |=>
      carry == $past(carry) && w_reg == $past(w_reg) && !file_wr_en)
    else $error("subroutine return changed state it must keep");

  a_rot_carry_out: assert property (
    @(posedge mclk) disable iff (!rstn)
    accept && op_code == rotate_left_carry_op |=>
      carry == $past(rot_cout) && op_ready)
    else $error("rotate carry wrong or took more than one cycle");

  a_rot_to_w: assert property (
    @(posedge mclk) disable iff (!rstn)
    accept && op_code == rotate_left_carry_op && op_dest == `RRE_DEST_W
    |=> w_reg == $past(rot_result) && !file_wr_en)
    else $error("rotate to working register misrouted");

  a_rot_to_file: assert property (
    @(posedge mclk) disable iff (!rstn)
    accept && op_code == rotate_left_carry_op && op_dest == `RRE_DEST_F
    |=> file_wr_en && file_wr_addr == $past(op_file_addr) &&
        file_wr_data == $past(rot_result) && w_reg == $past(w_reg))
    else $error("rotate write back misrouted");

  a_rot_no_pop: assert property (
    @(posedge mclk) disable iff (!rstn)
    accept && op_code == rotate_left_carry_op |->
      !stack_pop ##1 pc == $past(pc))
    else $error("rotate touched stack or pc");
endmodule

`default_nettype wire

// >>> hw/rre_defines.svh
`ifndef RRE_DEFINES_SVH
`define RRE_DEFINES_SVH

//--------------------------------------------------------------
// widths
//--------------------------------------------------------------
`define RRE_DATA_W 8
`define RRE_FADDR_W 7
`define RRE_PC_W 15

//--------------------------------------------------------------
// fields and reset values
//--------------------------------------------------------------
`define RRE_INT_EN_BIT 7
`define RRE_MSB_BIT 7
`define RRE_DEST_W 1'b0
`define RRE_DEST_F 1'b1
`define RRE_RST_BYTE 8'h00
`define RRE_RST_PC 15'h0000
`define RRE_RST_FADDR 7'h00
`define RRE_RST_BIT 1'b0

`endif

// >>> hw/rre_pkg.sv
`include "rre_defines.svh"
`default_nettype none

//--------------------------------------------------------------
// shared types
//--------------------------------------------------------------
package rre_pkg;
  typedef logic [`RRE_DATA_W-1:0] rre_byte_t; // data byte
  typedef logic [`RRE_FADDR_W-1:0] rre_faddr_t; // file address
  typedef logic [`RRE_PC_W-1:0] rre_pc_t; // program counter
  // decoded instruction presented to the executor
  typedef enum logic [2:0] {
    idle_op,
    return_from_interrupt_op,
    return_with_literal_op,
    return_from_sub_op,
    rotate_left_carry_op
  } rre_op_e;
  // executor sequencing
  typedef enum logic {
    st_ready,
    st_flush
  } rre_state_e;
endpackage

`default_nettype wire

// >>> hw/rre_rot_if.sv
`include "rre_defines.svh"
`default_nettype none

//--------------------------------------------------------------
// link between executor and rotate unit
//--------------------------------------------------------------
interface rre_rot_if;
  logic [`RRE_DATA_W-1:0] value_in; // operand byte
  logic carry_in; // old carry
  logic [`RRE_DATA_W-1:0] result; // rotated byte
  logic carry_out; // new carry
  modport unit (input value_in, input carry_in,
                output result, output carry_out);
  modport user (output value_in, output carry_in,
                input result, input carry_out);
endinterface

`default_nettype wire

// >>> hw/rre_rotate.sv
`include "rre_defines.svh"
`default_nettype none

//--------------------------------------------------------------
// rotate left through carry, pure combinational
//--------------------------------------------------------------
module rre_rotate (
  rre_rot_if.unit rot
);
  // old carry enters bit 0, old msb leaves as carry
  assign rot.result = {rot.value_in[`RRE_DATA_W-2:0], rot.carry_in};
  assign rot.carry_out = rot.value_in[`RRE_MSB_BIT];
endmodule

`default_nettype wire

// >>> tb/return_and_rotate_exec_tb_top.sv
`default_nettype none
module return_and_rotate_exec_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import rre_pkg::*;

  //------------------------------------------------------------
  // stimulus and observed signals
  //------------------------------------------------------------
  logic mclk = 1'b0;
  logic rstn = 1'b0; // held low from time zero
  logic op_valid = 1'b0;
  logic op_dest = 1'b0;
  logic int_enable_clear = 1'b0;
  rre_op_e op_code = idle_op;
  rre_byte_t op_literal = 8'h00;
  rre_byte_t file_rd_data = 8'h00;
  rre_faddr_t op_file_addr = 7'h00;
  rre_pc_t top_of_stack = 15'h0000;
  logic op_ready, stack_pop, file_wr_en, carry;
  rre_faddr_t file_rd_addr, file_wr_addr;
  rre_byte_t interrupt_control_reg, w_reg, file_wr_data;
  rre_pc_t pc;
  // expected state kept by the bench
  rre_byte_t e_w, e_wd;
  rre_faddr_t e_wa;
  rre_pc_t e_pc;
  logic e_c, e_ien, e_rdy, e_wen;
  int n_errors = 0;
  int checked = 0;
  int cycles = 0;

  always #25 mclk = ~mclk; // 20 MHz

  rre_exec uut (.mclk(mclk), .rstn(rstn), .op_valid(op_valid),
    .op_code(op_code), .op_literal(op_literal),
    .op_file_addr(op_file_addr), .op_dest(op_dest),
    .op_ready(op_ready), .stack_pop(stack_pop),
    .top_of_stack(top_of_stack), .file_rd_addr(file_rd_addr),
    .file_rd_data(file_rd_data), .file_wr_en(file_wr_en),
    .file_wr_addr(file_wr_addr), .file_wr_data(file_wr_data),
    .int_enable_clear(int_enable_clear),
    .interrupt_control_reg(interrupt_control_reg),
    .w_reg(w_reg), .carry(carry), .pc(pc));

  //------------------------------------------------------------
  // helpers
  //------------------------------------------------------------
  function automatic logic is_ret(rre_op_e c);
    return c inside {return_from_interrupt_op, return_with_literal_op,
                     return_from_sub_op};
  endfunction

  // one comparison, counted and reported on mismatch
  task automatic chk(string nm, logic [14:0] e, logic [14:0] g);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic complete_run;
    $display("mismatches %0d comparisons %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // advance expected state with the inputs seen at this edge
  task automatic model;
    logic take;
    logic [7:0] rot;
    take = op_valid && e_rdy;
    rot = {file_rd_data[6:0], e_c};
    e_wen = 1'b0;
    if (!rstn) begin
      {e_w, e_c, e_pc, e_ien, e_rdy} = {8'h00, 1'b0, 15'h0000, 2'b01};
    end else begin
      if (int_enable_clear) e_ien = 1'b0; // set below wins over clear
      e_rdy = !(take && is_ret(op_code));
      if (take && is_ret(op_code)) e_pc = top_of_stack;
      if (take && op_code == return_from_interrupt_op) e_ien = 1'b1;
      if (take && op_code == return_with_literal_op) e_w = op_literal;
      if (take && op_code == rotate_left_carry_op) begin
        e_wen = op_dest;
        if (op_dest) {e_wa, e_wd} = {op_file_addr, rot};
        else e_w = rot;
        e_c = file_rd_data[7];
      end
    end
  endtask

  // one clock: update model, drive new inputs, compare outputs, write address and data only on a write
  task automatic cyc(logic r, logic v, rre_op_e c, rre_byte_t lit,
                     rre_faddr_t a, logic d, rre_byte_t rd,
                     rre_pc_t t, logic g);
    @(posedge mclk);
    model();
    rstn <= r;
    op_valid <= v;
    op_code <= c;
    op_literal <= lit;
    op_file_addr <= a;
    op_dest <= d;
    file_rd_data <= rd;
    top_of_stack <= t;
    int_enable_clear <= g;
    #1;
    chk("pc", e_pc, pc);
    chk("w_reg", 15'(e_w), 15'(w_reg));
    chk("carry", 15'(e_c), 15'(carry));
    chk("int_ctl", {7'h00, e_ien, 7'h00}, 15'(interrupt_control_reg));
    chk("wr_en", 15'(e_wen), 15'(file_wr_en));
    if (e_wen) chk("wr_addr", 15'(e_wa), 15'(file_wr_addr));
    if (e_wen) chk("wr_data", 15'(e_wd), 15'(file_wr_data));
    chk("op_ready", 15'(e_rdy), 15'(op_ready));
    chk("pop", 15'(v && e_rdy && is_ret(c)), 15'(stack_pop));
    chk("rd_addr", 15'(a), 15'(file_rd_addr));
  endtask

  //------------------------------------------------------------
  // hang guard
  //------------------------------------------------------------
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      complete_run();
    end
  end

  //------------------------------------------------------------
  // main sequence
  //------------------------------------------------------------
  initial begin
    void'($urandom(32'h9757));
    repeat (3) cyc(0, 0, idle_op, 0, 0, 0, 0, 0, 0);
    cyc(1, 0, idle_op, 0, 0, 0, 0, 0, 0);
    // rotate to working reg, then back to back into the file
    cyc(1, 1, rotate_left_carry_op, 0, 7'h7F, 0, 8'hE6, 0, 0);
    cyc(1, 1, rotate_left_carry_op, 0, 7'h00, 1, 8'h80, 0, 0);
    // interrupt return with a clear at the same edge
    cyc(1, 1, return_from_interrupt_op, 0, 0, 0, 0, 15'h7FFF, 1);
    // wait state: a rotate offered now must be ignored
    cyc(1, 1, rotate_left_carry_op, 0, 7'h15, 1, 8'hFF, 0, 0);
    cyc(1, 1, return_with_literal_op, 8'hFF, 0, 0, 0, 0, 0);
    cyc(1, 1, return_from_sub_op, 8'h5A, 0, 0, 0, 15'h1234, 1);
    cyc(1, 1, return_from_sub_op, 0, 0, 0, 0, 15'h0001, 0);
    cyc(1, 1, idle_op, 8'h33, 7'h40, 1, 8'h81, 15'h2222, 0);
    // random traffic with occasional resets
    repeat (600) begin
      cyc(1'($urandom_range(0, 40) != 0), 1'($urandom_range(0, 3) != 0),
          rre_op_e'($urandom_range(0, 4)), 8'($urandom),
          7'($urandom), 1'($urandom), 8'($urandom), 15'($urandom),
          1'($urandom_range(0, 7) == 0));
    end
    repeat (2) cyc(1, 0, idle_op, 0, 0, 0, 0, 0, 0);
    complete_run();
  end
endmodule
`default_nettype wire
